// ==== hdl/tcu_pkg.sv ====
// constants and helpers for the timer compare unit
// Function
// - compare counter against both compare values continuously
// - compare flag sets one timer tick after match
// - flag clears on service or written one
// - interrupt request when flag and enable set
// - compare values buffered in pwm modes only
// - buffered value loads at top of count
// - cpu reaches buffer or working register by mode
// - force strobe acts like match, no flag
// - counter write blocks matches on next tick
// - output state survives waveform mode changes
// - output action unbuffered, force applies at once
// - nonzero action overrides pin data, not direction
// - action zero leaves output state unchanged
// - mode 0 counts up, wraps ff to 00
// - normal mode overflow flag when count wraps
// - normal mode counter writable at any time
// - mode 2 clears counter after channel a match
// - compare below count runs to wrap first
// - toggle action inverts channel a each match
// - toggle frequency is clock/(2*n*(1+compare))
// - match-clear mode overflow flag at max wrap
// - cpu counter write beats clear or count
// - clock select zero stops counter, stays accessible
// - max ff, bottom 00, top ff or compare a
package tcu_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int NUM_CH = 2;
    localparam int PRESC_W = 10;

    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_ACTION = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_CMP_A = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_CMP_B = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_PORT = 4'h7;

    localparam int CTRL_WGM_LSB = 0;
    localparam int CTRL_CS_LSB = 3;
    localparam int ACTION_W = 2;
    localparam int ACTION_LSB = 0;
    localparam int FORCE_LSB = 4;
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_CMP_LSB = 1;
    localparam int PORT_DATA_LSB = 0;
    localparam int PORT_DIR_LSB = 2;

    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_CLEAR_ON_MATCH = 3'h2;
    localparam int WGM_PWM_BIT = 0;
    localparam int WGM_TOPA_BIT = 2;
    localparam logic [2:0] CS_STOP = 3'h0;

    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_STEP = 8'h01;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [PRESC_W-1:0] PRESC_STEP = 10'h001;

    // tick when the low prescaler bits are all ones: /1 /8 /32 ... /1024
    localparam logic [PRESC_W-1:0] PRESC_MASK [8] = '{
        10'h000, 10'h000, 10'h007, 10'h01F,
        10'h03F, 10'h07F, 10'h0FF, 10'h3FF
    };

    function automatic logic tcu_apply_action(input logic [1:0] act,
                                              input logic cur);
        logic res;
        res = cur;
        unique case (act)
            ACT_NONE: res = cur;
            ACT_TOGGLE: res = ~cur;
            ACT_CLEAR: res = 1'b0;
            ACT_SET: res = 1'b1;
        endcase
        return res;
    endfunction : tcu_apply_action
endpackage : tcu_pkg

// ==== hdl/tcu_timer_compare.sv ====
// 8-bit timer counter with two compare channels and pin override
`timescale 1ns/1ps
module tcu_timer_compare
    import tcu_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    input wire logic irq_ack_ovf_i,
    input wire logic [NUM_CH-1:0] irq_ack_cmp_i,
    output logic irq_ovf_o,
    output logic [NUM_CH-1:0] irq_cmp_o,
    output logic [NUM_CH-1:0] compare_output_pin_o,
    output logic [NUM_CH-1:0] compare_output_oe_o
);

    logic [2:0] waveform_mode_sel;
    logic [2:0] clock_source_sel;
    logic [NUM_CH-1:0][1:0] output_action_sel;
    logic [7:0] timer_count;
    logic [NUM_CH-1:0][7:0] compare_value_chan;
    logic [NUM_CH-1:0][7:0] compare_buf;
    logic [NUM_CH-1:0] compare_flag_chan;
    logic overflow_flag;
    logic irq_en_ovf;
    logic [NUM_CH-1:0] irq_en_cmp;
    logic [NUM_CH-1:0] port_data;
    logic [NUM_CH-1:0] port_dir;
    logic [NUM_CH-1:0] compare_output_chan;
    logic [PRESC_W-1:0] presc;
    logic block_pend;

    logic wr_ctrl;
    logic wr_action;
    logic count_wr;
    logic wr_flags;
    logic [NUM_CH-1:0] wr_cmp;
    logic pwm_mode;
    logic clear_on_match_mode;
    logic tick;
    logic [7:0] top_value;
    logic at_top;
    logic clear_now;
    logic ovf_set;
    logic [NUM_CH-1:0] match_raw;
    logic [NUM_CH-1:0] match_hit;
    logic [NUM_CH-1:0] force_cmp;
    logic [NUM_CH-1:0] oc_event;
    logic [NUM_CH-1:0][1:0] event_action;
    logic [7:0] next_count;
    logic [DATA_W-1:0] rd_mux;

    // address decode
    always_comb begin
        wr_ctrl = reg_wr_i && (reg_addr_i == OFS_CTRL);
        wr_action = reg_wr_i && (reg_addr_i == OFS_ACTION);
        count_wr = reg_wr_i && (reg_addr_i == OFS_COUNT);
        wr_flags = reg_wr_i && (reg_addr_i == OFS_FLAGS);
        wr_cmp[0] = reg_wr_i && (reg_addr_i == OFS_CMP_A);
        wr_cmp[1] = reg_wr_i && (reg_addr_i == OFS_CMP_B);
    end

    // timer tick from the prescaler; stopped clock select gives no tick
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            presc <= '0;
        end else begin
            presc <= presc + PRESC_STEP;
        end
    end

    always_comb begin
        tick = (clock_source_sel != CS_STOP) &&
            ((presc & PRESC_MASK[clock_source_sel]) ==
             PRESC_MASK[clock_source_sel]);
    end

    // mode decode and counter control
    always_comb begin
        pwm_mode = waveform_mode_sel[WGM_PWM_BIT];
        clear_on_match_mode = (waveform_mode_sel == WGM_CLEAR_ON_MATCH);
        if (clear_on_match_mode ||
            (pwm_mode && waveform_mode_sel[WGM_TOPA_BIT])) begin
            top_value = compare_value_chan[0];
        end else begin
            top_value = COUNT_MAX;
        end
        at_top = (timer_count == top_value);
        for (int ch = 0; ch < NUM_CH; ch++) begin
            match_raw[ch] = (timer_count == compare_value_chan[ch]);
            // a pending counter write eats the match of this tick
            match_hit[ch] = tick && match_raw[ch] && !block_pend;
        end
        if (clear_on_match_mode) begin
            clear_now = match_hit[0];
        end else begin
            clear_now = pwm_mode && at_top;
        end
        ovf_set = tick && !count_wr &&
            ((timer_count == COUNT_MAX) || (pwm_mode && at_top));
        if (count_wr) begin
            next_count = reg_wdata_i;
        end else if (tick && clear_now) begin
            next_count = COUNT_BOTTOM;
        end else if (tick) begin
            // plain 8-bit wrap also rescues a missed match-clear top
            next_count = timer_count + COUNT_STEP;
        end else begin
            next_count = timer_count;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timer_count <= RST_BYTE;
        end else begin
            timer_count <= next_count;
        end
    end

    // block lasts until the next tick, however long the clock is stopped
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            block_pend <= 1'b0;
        end else if (count_wr) begin
            block_pend <= 1'b1;
        end else if (tick) begin
            block_pend <= 1'b0;
        end
    end

    // control registers
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            waveform_mode_sel <= WGM_NORMAL;
            clock_source_sel <= CS_STOP;
            output_action_sel <= '0;
            irq_en_ovf <= 1'b0;
            irq_en_cmp <= '0;
            port_data <= '0;
            port_dir <= '0;
        end else begin
            if (wr_ctrl) begin
                waveform_mode_sel <= reg_wdata_i[CTRL_WGM_LSB +: 3];
                clock_source_sel <= reg_wdata_i[CTRL_CS_LSB +: 3];
            end
            if (wr_action) begin
                // not buffered: next match already uses it
                output_action_sel <= reg_wdata_i[ACTION_LSB +: 4];
            end
            if (reg_wr_i && (reg_addr_i == OFS_IRQ_EN)) begin
                irq_en_ovf <= reg_wdata_i[FLAG_OVF_BIT];
                irq_en_cmp <= reg_wdata_i[FLAG_CMP_LSB +: NUM_CH];
            end
            if (reg_wr_i && (reg_addr_i == OFS_PORT)) begin
                port_data <= reg_wdata_i[PORT_DATA_LSB +: NUM_CH];
                port_dir <= reg_wdata_i[PORT_DIR_LSB +: NUM_CH];
            end
        end
    end

    // compare values: buffer in pwm modes, direct otherwise
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            compare_value_chan <= '0;
            compare_buf <= '0;
        end else begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                if (wr_cmp[ch]) begin
                    compare_buf[ch] <= reg_wdata_i;
                end
                if (wr_cmp[ch] && !pwm_mode) begin
                    compare_value_chan[ch] <= reg_wdata_i;
                end else if (pwm_mode && tick && at_top) begin
                    compare_value_chan[ch] <= compare_buf[ch];
                end
            end
        end
    end

    // compare output state; mode writes never touch it
    always_comb begin
        for (int ch = 0; ch < NUM_CH; ch++) begin
            force_cmp[ch] = wr_action && !pwm_mode &&
                reg_wdata_i[FORCE_LSB + ch];
            oc_event[ch] = force_cmp[ch] || (match_hit[ch] && !pwm_mode);
            if (force_cmp[ch]) begin
                // forcing applies the setting written with it
                event_action[ch] =
                    reg_wdata_i[ACTION_LSB + ACTION_W*ch +: ACTION_W];
            end else begin
                event_action[ch] = output_action_sel[ch];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            compare_output_chan <= '0;
        end else begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                if (oc_event[ch]) begin
                    // toggle period is 2*(1+compare) ticks in match-clear
                    compare_output_chan[ch] <= tcu_apply_action(
                        event_action[ch], compare_output_chan[ch]);
                end
            end
        end
    end

    // flags: a set in the same cycle as a clear wins
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            compare_flag_chan <= '0;
            overflow_flag <= 1'b0;
        end else begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                if (match_hit[ch]) begin
                    compare_flag_chan[ch] <= 1'b1;
                end else if (irq_ack_cmp_i[ch] ||
                             (wr_flags && reg_wdata_i[FLAG_CMP_LSB + ch])) begin
                    compare_flag_chan[ch] <= 1'b0;
                end
            end
            if (ovf_set) begin
                overflow_flag <= 1'b1;
            end else if (irq_ack_ovf_i ||
                         (wr_flags && reg_wdata_i[FLAG_OVF_BIT])) begin
                overflow_flag <= 1'b0;
            end
        end
    end

    // interrupt requests, one cycle behind the flags
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_cmp_o <= '0;
            irq_ovf_o <= 1'b0;
        end else begin
            irq_cmp_o <= compare_flag_chan & irq_en_cmp;
            irq_ovf_o <= overflow_flag && irq_en_ovf;
        end
    end

    // pin override; direction always from the port register
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            compare_output_pin_o <= '0;
            compare_output_oe_o <= '0;
        end else begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                if (output_action_sel[ch] != ACT_NONE) begin
                    compare_output_pin_o[ch] <= compare_output_chan[ch];
                end else begin
                    compare_output_pin_o[ch] <= port_data[ch];
                end
            end
            compare_output_oe_o <= port_dir;
        end
    end

    // read mux; force bits always read zero
    always_comb begin
        rd_mux = '0;
        unique case (reg_addr_i)
            OFS_CTRL: begin
                rd_mux[CTRL_WGM_LSB +: 3] = waveform_mode_sel;
                rd_mux[CTRL_CS_LSB +: 3] = clock_source_sel;
            end
            OFS_ACTION: rd_mux[ACTION_LSB +: 4] = output_action_sel;
            OFS_COUNT: rd_mux = timer_count;
            OFS_CMP_A: rd_mux = pwm_mode ? compare_buf[0] :
                compare_value_chan[0];
            OFS_CMP_B: rd_mux = pwm_mode ? compare_buf[1] :
                compare_value_chan[1];
            OFS_FLAGS: begin
                rd_mux[FLAG_OVF_BIT] = overflow_flag;
                rd_mux[FLAG_CMP_LSB +: NUM_CH] = compare_flag_chan;
            end
            OFS_IRQ_EN: begin
                rd_mux[FLAG_OVF_BIT] = irq_en_ovf;
                rd_mux[FLAG_CMP_LSB +: NUM_CH] = irq_en_cmp;
            end
            OFS_PORT: begin
                rd_mux[PORT_DATA_LSB +: NUM_CH] = port_data;
                rd_mux[PORT_DIR_LSB +: NUM_CH] = port_dir;
            end
            default: rd_mux = '0;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end else begin
            reg_rdata_o <= '0;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    a_match_flag_set: assert property (
        match_hit[0] |=> compare_flag_chan[0]
    ) else $error("flag a not set after match");

    a_ack_clears_flag: assert property (
        irq_ack_cmp_i[1] && !match_hit[1] |=> !compare_flag_chan[1]
    ) else $error("flag b not cleared by acknowledge");

    a_irq_from_flag: assert property (
        compare_flag_chan[0] && irq_en_cmp[0] |=> irq_cmp_o[0]
    ) else $error("compare a request missing");

    a_direct_cmp_write: assert property (
        wr_cmp[0] && !pwm_mode |=>
            compare_value_chan[0] == $past(reg_wdata_i)
    ) else $error("direct compare write lost");

    a_buffer_holds: assert property (
        pwm_mode && !(tick && at_top) |=> $stable(compare_value_chan[1])
    ) else $error("working compare changed off top");

    a_force_no_flag: assert property (
        force_cmp[0] && !match_hit[0] && !compare_flag_chan[0] |=>
            !compare_flag_chan[0]
    ) else $error("force set the flag");

    a_write_blocks_match: assert property (
        count_wr |=> (match_hit == '0)
    ) else $error("match after counter write");

    a_cpu_write_wins: assert property (
        count_wr |=> timer_count == $past(reg_wdata_i)
    ) else $error("counter write overridden");

    a_match_clears: assert property (
        clear_on_match_mode && match_hit[0] && !count_wr |=>
            timer_count == COUNT_BOTTOM
    ) else $error("counter not cleared on match");

    a_normal_counts_up: assert property (
        waveform_mode_sel == WGM_NORMAL && tick && !count_wr |=>
            timer_count == $past(timer_count) + COUNT_STEP
    ) else $error("normal mode did not increment");

    a_overflow_wrap: assert property (
        tick && !count_wr && timer_count == COUNT_MAX |=> overflow_flag
    ) else $error("overflow flag missing at wrap");

    a_stopped_holds: assert property (
        clock_source_sel == CS_STOP && !count_wr |=> $stable(timer_count)
    ) else $error("stopped counter moved");

    a_match_toggle: assert property (
        clear_on_match_mode && match_hit[0] && !force_cmp[0] &&
        output_action_sel[0] == ACT_TOGGLE |=>
            compare_output_chan[0] != $past(compare_output_chan[0])
    ) else $error("toggle missing on match");

    a_no_action_holds: assert property (
        output_action_sel[1] == ACT_NONE && !force_cmp[1] |=>
            $stable(compare_output_chan[1])
    ) else $error("output changed with no action");

    a_mode_keeps_state: assert property (
        wr_ctrl && !oc_event[0] |=> $stable(compare_output_chan[0])
    ) else $error("mode change altered output state");

    a_pin_override: assert property (
        output_action_sel[0] != ACT_NONE |=>
            compare_output_pin_o[0] == $past(compare_output_chan[0])
    ) else $error("pin not overridden");

endmodule : tcu_timer_compare

// ==== tb/tcu_isr_model.sv ====
// interrupt service side of the cpu core driving the acknowledge pulses
`timescale 1ns/1ps
module tcu_isr_model (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic irq_ovf_i,
    input wire logic [1:0] irq_cmp_i,
    input wire logic [2:0] svc_en_i,
    input wire logic slow_i,
    output logic ack_ovf_o,
    output logic [1:0] ack_cmp_o
);
    logic [2:0] req;
    logic [2:0] ack;
    logic [3:0] wait_cnt [3];

    // software never rewrites the counter from here
    assign req = {irq_cmp_i, irq_ovf_i} & svc_en_i;
    assign ack_ovf_o = ack[0];
    assign ack_cmp_o = ack[2:1];

    // vector entry takes 2 or 6 cycles; hold-off outlasts the request drop
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                wait_cnt[i] <= 4'h0;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                ack[i] <= (wait_cnt[i] == 4'h3);
                if (wait_cnt[i] != 4'h0) begin
                    wait_cnt[i] <= wait_cnt[i] - 4'h1;
                end else if (req[i]) begin
                    wait_cnt[i] <= slow_i ? 4'h8 : 4'h4;
                end
            end
        end
    end
endmodule : tcu_isr_model

// ==== tb/test_tcu_timer_compare.sv ====
// self-checking bench for the timer compare unit
`timescale 1ns/1ps
module test_tcu_timer_compare
    import tcu_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 4'h0;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic irq_ack_ovf;
    logic irq_ovf;
    logic [NUM_CH-1:0] irq_ack_cmp;
    logic [NUM_CH-1:0] irq_cmp;
    logic [NUM_CH-1:0] pin;
    logic [NUM_CH-1:0] oe;
    logic [2:0] svc_en = 3'h0;
    logic slow = 1'b0;
    logic [7:0] exp_q [$];
    int failures = 0;
    int cmp_count = 0;
    int acks = 0;
    int seed = 66;
    int per [3] = '{4, 32, 128};
    // {ctrl, expected pin, action byte}
    logic [15:0] frc [8] = '{16'h0093, 16'h0012, 16'h0091, 16'h0211,
                             16'h0090, 16'h0201, 16'h0113, 16'h0003};

    tcu_timer_compare u_tcu_timer_compare (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata),
        .irq_ack_ovf_i(irq_ack_ovf),
        .irq_ack_cmp_i(irq_ack_cmp),
        .irq_ovf_o(irq_ovf),
        .irq_cmp_o(irq_cmp),
        .compare_output_pin_o(pin),
        .compare_output_oe_o(oe)
    );

    tcu_isr_model u_tcu_isr_model (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .irq_ovf_i(irq_ovf),
        .irq_cmp_i(irq_cmp),
        .svc_en_i(svc_en),
        .slow_i(slow),
        .ack_ovf_o(irq_ack_ovf),
        .ack_cmp_o(irq_ack_cmp)
    );

    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : check

    task automatic final_report();
        $display("counts: %0d compares, %0d failures", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    task automatic stuck();
        failures++;
        $display("CHECK FAILED at %0t: wait ran out, got %h expected %h",
                 $time, 1'b0, 1'b1);
        final_report();
    endtask : stuck

    // read data stands only in the cycle after the strobe
    always @(posedge clk_sys_i) begin
        if (rd_d) begin
            check(reg_rdata, exp_q.pop_front());
        end
        rd_d <= reg_rd;
        if (irq_ack_cmp[0]) begin
            acks++;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : cyc

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic wait_lvl(input int sel, input logic lvl);
        logic [2:0] v;
        int n;
        n = 0;
        v = {irq_cmp, irq_ovf};
        while (v[sel] !== lvl && n < 4000) begin
            cyc(1);
            v = {irq_cmp, irq_ovf};
            n++;
        end
        if (n == 4000) begin
            stuck();
        end
    endtask : wait_lvl

    task automatic next_edge(output int n);
        logic p;
        p = pin[0];
        n = 0;
        while (pin[0] === p && n < 5000) begin
            cyc(1);
            n++;
        end
        if (n == 5000) begin
            stuck();
        end
    endtask : next_edge

    // counter goes last so its match blocking covers the first tick
    task automatic setup(input logic [7:0] cnt, input logic [7:0] cmp,
                         input logic [7:0] en);
        wr(OFS_CTRL, 8'h00);
        wr(OFS_FLAGS, 8'h07);
        wr(OFS_CMP_A, cmp);
        wr(OFS_IRQ_EN, en);
        wr(OFS_COUNT, cnt);
    endtask : setup

    initial begin
        logic [7:0] v;
        int n;
        repeat (3) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(4'(a), 8'h00);
        end
        wr(4'hC, 8'hFF);
        rd(4'hC, 8'h00);
        cyc(1);
        check({6'h0, oe}, 8'h00);
        $display("test reset done");
        repeat (4) begin
            v = 8'($random(seed));
            wr(OFS_COUNT, v);
            rd(OFS_COUNT, v);
            wr(OFS_CMP_A, ~v);
            rd(OFS_CMP_A, ~v);
        end
        wr(OFS_COUNT, 8'h40);
        wr(OFS_CMP_B, 8'h11);
        wr(OFS_CTRL, 8'h01);
        wr(OFS_CMP_B, 8'h22);
        rd(OFS_CMP_B, 8'h22);
        wr(OFS_CTRL, 8'h00);
        rd(OFS_CMP_B, 8'h11);
        // running pwm: buffered 22 reaches the working register at top
        wr(OFS_CTRL, 8'h09);
        cyc(300);
        wr(OFS_CTRL, 8'h00);
        rd(OFS_CMP_B, 8'h22);
        $display("test access done");
        wr(OFS_CMP_B, 8'h80);
        setup(8'hFD, 8'h80, 8'h01);
        wr(OFS_CTRL, 8'h08);
        wait_lvl(0, 1'b1);
        wr(OFS_CTRL, 8'h00);
        rd(OFS_FLAGS, 8'h01);
        wr(OFS_FLAGS, 8'h01);
        rd(OFS_FLAGS, 8'h00);
        cyc(1);
        check({7'h0, irq_ovf}, 8'h00);
        $display("test overflow done");
        wr(OFS_CMP_B, 8'h10);
        setup(8'h0C, 8'h80, 8'h04);
        svc_en <= 3'b100;
        slow <= 1'b1;
        wr(OFS_CTRL, 8'h08);
        wait_lvl(2, 1'b1);
        wait_lvl(2, 1'b0);
        wr(OFS_CTRL, 8'h00);
        rd(OFS_FLAGS, 8'h00);
        $display("test service done");
        for (int i = 0; i < 2; i++) begin
            setup(8'h20 - 8'(i), 8'h20, 8'h00);
            wr(OFS_CTRL, 8'h08);
            cyc(6);
            wr(OFS_CTRL, 8'h00);
            rd(OFS_FLAGS, i == 0 ? 8'h00 : 8'h02);
        end
        $display("test blocking done");
        setup(8'h00, 8'h03, 8'h02);
        wr(OFS_ACTION, 8'h01);
        wr(OFS_PORT, 8'h04);
        svc_en <= 3'b010;
        slow <= 1'b0;
        for (int s = 1; s < 4; s++) begin
            wr(OFS_CTRL, 8'(s * 8 + 2));
            next_edge(n);
            next_edge(n);
            check(8'(n), 8'(per[s - 1]));
        end
        check({6'h0, oe}, 8'h01);
        check({7'h0, acks != 0}, 8'h01);
        wr(OFS_CTRL, 8'h00);
        cyc(10);
        rd(OFS_FLAGS, 8'h00);
        $display("test toggle done");
        svc_en <= 3'b000;
        wr(OFS_ACTION, 8'h00);
        setup(8'hF0, 8'h10, 8'h01);
        wr(OFS_CTRL, 8'h0A);
        wait_lvl(0, 1'b1);
        wr(OFS_CTRL, 8'h00);
        rd(OFS_FLAGS, 8'h01);
        $display("test wrap done");
        wr(OFS_FLAGS, 8'h07);
        wr(OFS_PORT, 8'h0F);
        foreach (frc[i]) begin
            wr(OFS_CTRL, frc[i][15:8]);
            wr(OFS_ACTION, {2'h0, frc[i][5:0]});
            cyc(2);
            check({4'h0, oe, pin}, {7'h07, frc[i][7]});
        end
        rd(OFS_FLAGS, 8'h00);
        $display("test force done");
        cyc(3);
        final_report();
    end
endmodule : test_tcu_timer_compare
